// file: timer_params.svh
/*
 Constants for the auto-reload timer: control bit positions, reset
 values and clock divider figures.
 Assumes inclusion by bare name from the timer design files.
*/
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
`define CTL_HIGH_FLAG_BIT 7
`define CTL_LOW_FLAG_BIT 6
`define CTL_LOW_IRQ_EN_BIT 5
`define CTL_CAPTURE_EN_BIT 4
`define CTL_SPLIT_BIT 3
`define CTL_RUN_BIT 2
`define CTL_UNUSED_BIT 1
`define CTL_EXT_CLK_BIT 0
`define CTL_RESET 8'h00
`define BYTE_RESET 8'h00
`define SYS_DIV 12
`define EXT_DIV 8
`endif

// file: timer_pkg.sv
/*
 Types shared by the timer design files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package timer_pkg;
	typedef enum logic [1:0] {
		SRC_DIV12 = 2'b00,
		SRC_EXT8 = 2'b01,
		SRC_SYS = 2'b10
	} clk_src_t;
endpackage

// file: tick_gen.sv
/*
 Tick generator: system clock divided by 12 and a synchronised external
 clock divided by 8, with a falling-edge capture pulse.
 Assumes ext_clk_in is asynchronous to ref_clk_in and slower than half it.
*/
`timescale 1ns/1ps
`include "timer_params.svh"
module tick_gen (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic ext_clk_in,
	output logic div12_tick_out,
	output logic ext8_tick_out,
	output logic ext8_fall_out
);
	logic [3:0] pre_q;
	logic [1:0] sync_q;
	logic ext_prev_q;
	logic [2:0] ext_cnt_q;
	logic ext_rise;
	logic pre_wrap;
	assign ext_rise = sync_q[1] & ~ext_prev_q;
	assign pre_wrap = (pre_q == 4'(`SYS_DIV - 1));
	////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pre_q <= 4'h0;
			div12_tick_out <= 1'b0;
		end else begin
			pre_q <= pre_wrap ? 4'h0 : pre_q + 4'h1;
			div12_tick_out <= pre_wrap;
		end
	end
	////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync_q <= 2'b00;
			ext_prev_q <= 1'b0;
			ext_cnt_q <= 3'h0;
			ext8_tick_out <= 1'b0;
			ext8_fall_out <= 1'b0;
		end else begin
			sync_q <= {sync_q[0], ext_clk_in};
			ext_prev_q <= sync_q[1];
			if (ext_rise)
				ext_cnt_q <= ext_cnt_q + 3'h1;
			ext8_tick_out <= ext_rise && (ext_cnt_q == 3'(`EXT_DIV - 1));
			// Divided clock high for counts 0..3, falls entering 4
			ext8_fall_out <= ext_rise &&
				(ext_cnt_q == 3'(`EXT_DIV / 2 - 1));
		end
	end
endmodule // tick_gen

// file: auto_reload_timer.sv
/*
 Auto-reload timer: one 16-bit or two 8-bit counters, with an
 external oscillator capture mode.
 Assumes control and data writes arrive on the system clock, one per cycle.
*/
`timescale 1ns/1ps
`include "timer_params.svh"
module auto_reload_timer #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic ext_clk_in,
	input wire logic ctl_wr_in,
	input wire logic [7:0] ctl_wdata_in,
	input wire logic count_low_wr_in,
	input wire logic count_high_wr_in,
	input wire logic reload_low_wr_in,
	input wire logic reload_high_wr_in,
	input wire logic [WIDTH-1:0] wdata_in,
	input wire logic high_byte_clk_sel_in,
	input wire logic low_byte_clk_sel_in,
	input wire logic timer_irq_en_in,
	output logic [7:0] timer_control_out,
	output logic [WIDTH-1:0] count_low_byte_out,
	output logic [WIDTH-1:0] count_high_byte_out,
	output logic [WIDTH-1:0] reload_low_byte_out,
	output logic [WIDTH-1:0] reload_high_byte_out,
	output logic timer_irq_out
);
	logic div12_tick, ext8_tick, ext8_fall;
	logic [WIDTH-1:0] lo_q, hi_q, rl_lo_q, rl_hi_q;
	logic hflag_q, lflag_q, lien_q, cap_q, split_q, run_q, xclk_q;
	logic lo_tick, hi_tick, lo_wrap, hi_wrap, lo_ovf, hi_ovf, cap_evt;
	logic [WIDTH-1:0] lo_d, hi_d;
	logic hflag_d, lflag_d, irq_d;
	timer_pkg::clk_src_t lo_src, hi_src;

	default clocking cb_sys @(posedge ref_clk_in);
	endclocking
	default disable iff (!nrst_in);

	tick_gen u_tick (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.ext_clk_in(ext_clk_in),
		.div12_tick_out(div12_tick),
		.ext8_tick_out(ext8_tick),
		.ext8_fall_out(ext8_fall)
	);
	////////////////////////////////////////////////////////////////////
	// Clock source selection per byte
	assign lo_src = low_byte_clk_sel_in ? timer_pkg::SRC_SYS :
		(xclk_q ? timer_pkg::SRC_EXT8 : timer_pkg::SRC_DIV12);
	assign hi_src = high_byte_clk_sel_in ? timer_pkg::SRC_SYS :
		(xclk_q ? timer_pkg::SRC_EXT8 : timer_pkg::SRC_DIV12);
	// Capture mode blocks external-clock counting on the low byte only; the high byte still counts in split mode
	assign lo_tick = (lo_src == timer_pkg::SRC_SYS) ||
		(lo_src == timer_pkg::SRC_DIV12 && div12_tick) ||
		(lo_src == timer_pkg::SRC_EXT8 && ext8_tick && !cap_q);
	assign hi_tick = (hi_src == timer_pkg::SRC_SYS) ||
		(hi_src == timer_pkg::SRC_DIV12 && div12_tick) ||
		(hi_src == timer_pkg::SRC_EXT8 && ext8_tick);
	////////////////////////////////////////////////////////////////////
	// Count and wrap decode
	assign lo_wrap = &lo_q;
	assign hi_wrap = &hi_q;
	// 16-bit counts on the low-byte clock; split gates high byte only
	assign lo_ovf = (split_q ? lo_tick : (run_q && lo_tick)) && lo_wrap;
	assign hi_ovf = split_q ? (run_q && hi_tick && hi_wrap) :
		(lo_ovf && hi_wrap);
	assign cap_evt = cap_q && ext8_fall;

	always_comb begin
		lo_d = lo_q;
		hi_d = hi_q;
		if (split_q) begin
			if (lo_tick)
				lo_d = lo_wrap ? rl_lo_q : lo_q + 1'b1;
			if (run_q && hi_tick)
				hi_d = hi_wrap ? rl_hi_q : hi_q + 1'b1;
		end else if (run_q && lo_tick) begin
			if (lo_wrap && hi_wrap) begin
				lo_d = rl_lo_q;
				hi_d = rl_hi_q;
			end else begin
				lo_d = lo_q + 1'b1;
				hi_d = lo_wrap ? hi_q + 1'b1 : hi_q;
			end
		end
		if (count_low_wr_in)
			lo_d = wdata_in;
		if (count_high_wr_in)
			hi_d = wdata_in;
	end
	////////////////////////////////////////////////////////////////////
	// Flags: a hardware set wins over a software clear
	always_comb begin
		hflag_d = hflag_q;
		lflag_d = lflag_q;
		if (ctl_wr_in) begin
			hflag_d = ctl_wdata_in[`CTL_HIGH_FLAG_BIT];
			lflag_d = ctl_wdata_in[`CTL_LOW_FLAG_BIT];
		end
		if (hi_ovf || cap_evt)
			hflag_d = 1'b1;
		if (lo_ovf)
			lflag_d = 1'b1;
	end
	// Low flag only requests when its enable is set
	assign irq_d = timer_irq_en_in &&
		(hflag_d || (lien_q && lflag_d));
	////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			{hflag_q, lflag_q, lien_q, cap_q} <= 4'h0;
			{split_q, run_q, xclk_q} <= 3'h0;
			timer_irq_out <= 1'b0;
		end else begin
			hflag_q <= hflag_d;
			lflag_q <= lflag_d;
			timer_irq_out <= irq_d;
			if (ctl_wr_in) begin
				lien_q <= ctl_wdata_in[`CTL_LOW_IRQ_EN_BIT];
				cap_q <= ctl_wdata_in[`CTL_CAPTURE_EN_BIT];
				split_q <= ctl_wdata_in[`CTL_SPLIT_BIT];
				run_q <= ctl_wdata_in[`CTL_RUN_BIT];
				xclk_q <= ctl_wdata_in[`CTL_EXT_CLK_BIT];
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lo_q <= WIDTH'(`BYTE_RESET);
			hi_q <= WIDTH'(`BYTE_RESET);
			rl_lo_q <= WIDTH'(`BYTE_RESET);
			rl_hi_q <= WIDTH'(`BYTE_RESET);
		end else begin
			lo_q <= lo_d;
			hi_q <= hi_d;
			if (cap_evt) begin
				rl_lo_q <= lo_q;
				rl_hi_q <= hi_q;
			end else begin
				if (reload_low_wr_in)
					rl_lo_q <= wdata_in;
				if (reload_high_wr_in)
					rl_hi_q <= wdata_in;
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// Output view, registered
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			timer_control_out <= `CTL_RESET;
			count_low_byte_out <= WIDTH'(`BYTE_RESET);
			count_high_byte_out <= WIDTH'(`BYTE_RESET);
			reload_low_byte_out <= WIDTH'(`BYTE_RESET);
			reload_high_byte_out <= WIDTH'(`BYTE_RESET);
		end else begin
			timer_control_out <= {hflag_q, lflag_q, lien_q, cap_q,
				split_q, run_q, 1'b0, xclk_q};
			count_low_byte_out <= lo_q;
			count_high_byte_out <= hi_q;
			reload_low_byte_out <= rl_lo_q;
			reload_high_byte_out <= rl_hi_q;
		end
	end
	////////////////////////////////////////////////////////////////////
	sequence s_full_wrap;
		!split_q && run_q && lo_tick && lo_wrap && hi_wrap;
	endsequence
	sequence s_no_count_wr;
		!count_low_wr_in && !count_high_wr_in;
	endsequence
	a_full_reload: assert property (
		(s_full_wrap and s_no_count_wr)
		|=> lo_q == $past(rl_lo_q) && hi_q == $past(rl_hi_q) && hflag_q)
		else $error("16-bit wrap did not reload");
	a_split_low: assert property (
		split_q && lo_tick && !lo_wrap && !count_low_wr_in
		|=> lo_q == $past(lo_q) + 1'b1)
		else $error("split low byte did not count");
	a_split_hold: assert property (
		split_q && !run_q && !count_high_wr_in |=> $stable(hi_q))
		else $error("stopped high byte moved");
	a_split_lflag: assert property (
		split_q && lo_tick && lo_wrap
		|=> (lflag_q && lo_q == $past(rl_lo_q)) || $past(count_low_wr_in))
		else $error("low wrap missed flag");
	a_flag_sticky: assert property (
		hflag_q && !ctl_wr_in |=> hflag_q)
		else $error("high flag cleared by hardware");
	a_capture_copy: assert property (
		cap_evt
		|=> rl_lo_q == $past(lo_q) && rl_hi_q == $past(hi_q) && hflag_q)
		else $error("capture did not copy count");
	a_irq_follow: assert property (
		##1 timer_irq_out == ($past(timer_irq_en_in) &&
		(hflag_q || ($past(lien_q) && lflag_q))))
		else $error("interrupt does not follow flags");
	a_irq_lowonly: assert property (
		!hflag_q && !lien_q && !hi_ovf && !cap_evt && !ctl_wr_in
		|=> !timer_irq_out)
		else $error("low flag raised interrupt while disabled");
	a_ctl_bit1: assert property (
		!timer_control_out[`CTL_UNUSED_BIT])
		else $error("unused control bit not zero");
endmodule // auto_reload_timer

// file: tb_auto_reload_timer.sv
/*
 Self-checking bench for the auto-reload timer.
 Assumes timer_params.svh and the design files are compiled first.
*/
`timescale 1ns/1ps
`include "timer_params.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
	bad_count++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb_auto_reload_timer;
	logic ref_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic ext_clk_in = 1'b0;
	logic ctl_wr_in = 1'b0;
	logic [7:0] ctl_wdata_in = 8'h00;
	logic [3:0] byte_wr = 4'h0;
	logic [7:0] wdata_in = 8'h00;
	logic high_sel = 1'b0;
	logic low_sel = 1'b0;
	logic irq_en = 1'b0;
	logic [7:0] ctl_out;
	logic [7:0] cnt_lo, cnt_hi, rl_lo, rl_hi;
	logic irq_out;
	logic [15:0] r, c1, c2;
	int bad_count = 0;
	int num_checks = 0;
	int cyc = 0;
	auto_reload_timer DUT (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
		.ext_clk_in(ext_clk_in), .ctl_wr_in(ctl_wr_in),
		.ctl_wdata_in(ctl_wdata_in), .count_low_wr_in(byte_wr[0]),
		.count_high_wr_in(byte_wr[1]), .reload_low_wr_in(byte_wr[2]),
		.reload_high_wr_in(byte_wr[3]), .wdata_in(wdata_in),
		.high_byte_clk_sel_in(high_sel), .low_byte_clk_sel_in(low_sel),
		.timer_irq_en_in(irq_en), .timer_control_out(ctl_out),
		.count_low_byte_out(cnt_lo), .count_high_byte_out(cnt_hi),
		.reload_low_byte_out(rl_lo), .reload_high_byte_out(rl_hi),
		.timer_irq_out(irq_out));
	initial begin
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		forever #500 ext_clk_in = ~ext_clk_in;
	end
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	//////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wr_ctl(input logic [7:0] d);
		@(negedge ref_clk_in);
		ctl_wr_in = 1'b1;
		ctl_wdata_in = d;
		@(negedge ref_clk_in);
		ctl_wr_in = 1'b0;
	endtask
	// Byte index: 0 count low, 1 count high, 2 reload low, 3 reload high
	task automatic wr_byte(input int idx, input logic [7:0] d);
		@(negedge ref_clk_in);
		byte_wr[idx] = 1'b1;
		wdata_in = d;
		@(negedge ref_clk_in);
		byte_wr = 4'h0;
	endtask
	task automatic wait_bit(input int b);
		int n;
		n = 0;
		repeat (2) @(negedge ref_clk_in);
		while (ctl_out[b] !== 1'b1 && n < 3000) begin
			@(negedge ref_clk_in);
			n++;
		end
		`CHK("flag wait", 1'b1, ctl_out[b])
	endtask
	// Counts of a per-cycle count clock between two captures
	function automatic logic [15:0] capture_span(input int ext_half_ns,
		input int clk_ns);
		return 16'((2 * ext_half_ns * `EXT_DIV) / clk_ns);
	endfunction
	//////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h35FF));
		repeat (10) @(negedge ref_clk_in);
		nrst_in = 1'b1;
		`CHK("ctl reset", 8'h00, ctl_out)
		`CHK("count reset", 16'h0000, {cnt_hi, cnt_lo})
		wr_ctl(8'h02);
		repeat (2) @(negedge ref_clk_in);
		`CHK("unused bit", 8'h00, ctl_out)
		// 16-bit rollover on divided system clock
		r = 16'($urandom_range(16'hEFFF, 16'h0000)) & 16'hFF7F;
		wr_byte(2, r[7:0]);
		wr_byte(3, r[15:8]);
		wr_byte(0, 8'hFF);
		wr_byte(1, 8'hFF);
		irq_en = 1'b1;
		wr_ctl(8'h04);
		wait_bit(`CTL_HIGH_FLAG_BIT);
		`CHK("reload 16", r, {cnt_hi, cnt_lo})
		`CHK("low flag 16", 1'b1, ctl_out[`CTL_LOW_FLAG_BIT])
		`CHK("irq 16", 1'b1, irq_out)
		repeat (30) @(negedge ref_clk_in);
		`CHK("flag kept", 1'b1, ctl_out[`CTL_HIGH_FLAG_BIT])
		`CHK("irq kept", 1'b1, irq_out)
		wr_ctl(8'h04);
		repeat (2) @(negedge ref_clk_in);
		`CHK("flags cleared", 2'b00, ctl_out[7:6])
		`CHK("irq cleared", 1'b0, irq_out)
		// Low-byte wrap interrupt in 16-bit mode
		wr_ctl(8'h00);
		wr_byte(1, 8'h12);
		wr_byte(0, 8'hFF);
		wr_ctl(8'h24);
		wait_bit(`CTL_LOW_FLAG_BIT);
		`CHK("no high flag", 1'b0, ctl_out[`CTL_HIGH_FLAG_BIT])
		`CHK("carry", 8'h13, cnt_hi)
		`CHK("low irq", 1'b1, irq_out)
		irq_en = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		`CHK("irq masked", 1'b0, irq_out)
		irq_en = 1'b1;
		// Split mode on external clock over 8, run clear
		wr_ctl(8'h00);
		r = 16'($urandom);
		wr_byte(2, r[7:0]);
		wr_byte(3, r[15:8]);
		wr_byte(0, 8'hFF);
		wr_byte(1, 8'h55);
		wr_ctl(8'h09);
		wait_bit(`CTL_LOW_FLAG_BIT);
		`CHK("split low", r[7:0], cnt_lo)
		`CHK("high held", 8'h55, cnt_hi)
		`CHK("split no high", 1'b0, ctl_out[`CTL_HIGH_FLAG_BIT])
		`CHK("low irq off", 1'b0, irq_out)
		wr_byte(1, 8'hFF);
		wr_ctl(8'h0D);
		wait_bit(`CTL_HIGH_FLAG_BIT);
		`CHK("split high", r[15:8], cnt_hi)
		`CHK("split irq", 1'b1, irq_out)
		// High byte on the system clock counts every cycle
		high_sel = 1'b1;
		wr_byte(1, 8'h00);
		repeat (10) @(negedge ref_clk_in);
		`CHK("high system_clock", 8'h09, cnt_hi)
		high_sel = 1'b0;
		// Capture mode on system clock, external over 8 is 80 cycles
		wr_ctl(8'h00);
		low_sel = 1'b1;
		wr_byte(0, 8'h00);
		wr_byte(1, 8'h00);
		wr_ctl(8'h14);
		wait_bit(`CTL_HIGH_FLAG_BIT);
		c1 = {rl_hi, rl_lo};
		wr_ctl(8'h14);
		wait_bit(`CTL_HIGH_FLAG_BIT);
		c2 = {rl_hi, rl_lo};
		`CHK("capture span", capture_span(500, 100), c2 - c1)
		`CHK("capture mode", 1'b1, ctl_out[`CTL_CAPTURE_EN_BIT])
		complete_run();
	end
endmodule // tb_auto_reload_timer
